/* src/hub_link_regs_pkg.sv */
package hub_link_regs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] VC1_STATUS_OFS   = 12'h026;
  localparam logic [11:0] VC1_STATUS_DWORD = 12'h024;
  localparam logic [11:0] LINK_CAP_OFS     = 12'h084;
  localparam int          VC1_STATUS_LANE  = 2;

  // ****************************************
  // Field layouts and defaults
  // ****************************************
  localparam logic [15:0] VC1_STATUS_RESET = 16'h0002;
  localparam int          PENDING_BIT      = 1;
  localparam logic [31:0] LINK_CAP_RESET   = 32'h0001_2c41;
  localparam int          LATENCY_LSB      = 15;
  localparam int          LATENCY_MSB      = 17;
  localparam logic [2:0]  LATENCY_RESET    = 3'h2;
  localparam logic [2:0]  LATENCY_UNDER_1US = 3'h0;
  localparam logic [2:0]  LATENCY_OVER_64US = 3'h7;
  localparam logic [2:0]  CAP_RSVD_14_12   = 3'h2;
  localparam logic [1:0]  PM_SUPPORT_CODE  = 2'h3;
  localparam logic [5:0]  MAX_LANES        = 6'h04;
  localparam logic [3:0]  MAX_SPEED_2G5    = 4'h1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic dl_down;
    logic fc_init2_exit;
    logic chan1_enable;
  } link_state_t;

endpackage : hub_link_regs_pkg

/* src/hub_link_vc1_status_and_caps.sv */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Pending bit reads 1 while channel one initialises or disables, else 0.
// - Pending sets on reset, on channel one disabled, or on link down.
// - Pending clears only when flow-control init stage two exits for channel.
// - Exit latency field bits 17:15, default 010b, locks after first write.
// - Latency codes are doubling ranges, 000 under 1 us, 111 over 64 us.
// - Bits 11:10 read fixed 11b, L1 entry supported.
// - Bits 9:4 read fixed maximum lane count 04h.
// - Bits 3:0 read fixed speed code 1h, 2.5 Gb/s.
// - Channel active the cycle after pending reads clear and enable bit reads 1.
module hub_link_vc1_status_and_caps (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  // Register access in the base region
  input  wire hub_link_regs_pkg::reg_req_t    reg_req,
  output var  hub_link_regs_pkg::reg_rsp_t    reg_rsp,
  // Link and channel state from the training logic
  input  wire hub_link_regs_pkg::link_state_t link_state,
  // Status towards the rest of the hub
  output logic                                chan1_negotiation_pending,
  output logic [2:0]                          l1_exit_latency,
  output logic                                chan1_active
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hits(input logic [11:0] addr,
                                input logic [11:0] ofs);
    hits = (addr[11:2] == ofs[11:2]);
  endfunction : hits

  logic       latency_locked;
  logic       wr_cap;
  logic       lane1_wr;
  logic       lane2_wr;
  logic [2:0] next_latency;
  logic       fc_done;

  assign wr_cap   = reg_req.valid && reg_req.write
                    && hits(reg_req.addr, hub_link_regs_pkg::LINK_CAP_OFS);
  assign lane1_wr = wr_cap && reg_req.byte_en[1];
  assign lane2_wr = wr_cap && reg_req.byte_en[2];
  assign fc_done  = link_state.fc_init2_exit && link_state.chan1_enable
                    && !link_state.dl_down;

  // ****************************************
  // Negotiation pending
  // ****************************************
  // Set terms win over the clear so a link drop is never lost
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      chan1_negotiation_pending <= 1'b1;
    end else if (link_state.dl_down || !link_state.chan1_enable) begin
      chan1_negotiation_pending <= 1'b1;
    end else if (fc_done) begin
      chan1_negotiation_pending <= 1'b0;
    end
  end

  // Enable alone is not enough while negotiation is still running
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      chan1_active <= 1'b0;
    end else begin
      chan1_active <= !chan1_negotiation_pending
                      && link_state.chan1_enable;
    end
  end

  // ****************************************
  // Exit latency, write once
  // ****************************************
  // A split write updates its lane only and still locks the field
  always_comb begin
    next_latency = l1_exit_latency;
    if (lane1_wr) begin
      next_latency[0] = reg_req.wdata[hub_link_regs_pkg::LATENCY_LSB];
    end
    if (lane2_wr) begin
      next_latency[2:1] = reg_req.wdata[hub_link_regs_pkg::LATENCY_MSB -: 2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      l1_exit_latency <= hub_link_regs_pkg::LATENCY_RESET;
      latency_locked  <= 1'b0;
    end else if (!latency_locked && (lane1_wr || lane2_wr)) begin
      l1_exit_latency <= next_latency;
      latency_locked  <= 1'b1;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  function automatic logic [31:0] cap_word(input logic [2:0] lat);
    cap_word = {14'h0000, lat, hub_link_regs_pkg::CAP_RSVD_14_12,
                hub_link_regs_pkg::PM_SUPPORT_CODE,
                hub_link_regs_pkg::MAX_LANES,
                hub_link_regs_pkg::MAX_SPEED_2G5};
  endfunction : cap_word

  // Every request gets an ack next cycle; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack   <= reg_req.valid;
      reg_rsp.rdata <= 32'h0000_0000;
      if (reg_req.valid && !reg_req.write) begin
        if (hits(reg_req.addr, hub_link_regs_pkg::VC1_STATUS_DWORD)) begin
          reg_rsp.rdata[31:16] <= {14'h0000, chan1_negotiation_pending,
                                   1'b0};
        end else if (hits(reg_req.addr,
                          hub_link_regs_pkg::LINK_CAP_OFS)) begin
          reg_rsp.rdata <= cap_word(l1_exit_latency);
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence link_lost_s;
    link_state.dl_down || !link_state.chan1_enable;
  endsequence

  sequence fc_done_s;
    fc_done && !link_state.dl_down && link_state.chan1_enable;
  endsequence

  property pending_sets_p;
    @(posedge core_clk) disable iff (!rstn)
      link_lost_s |=> chan1_negotiation_pending;
  endproperty

  pending_set_a: assert property (pending_sets_p)
    else $error("Pending not set after link loss");

  pending_clear_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      fc_done_s |=> !chan1_negotiation_pending)
    else $error("Pending not cleared after init exit");

  clear_cause_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      $fell(chan1_negotiation_pending) |-> $past(fc_done))
    else $error("Pending cleared without init exit");

  pending_after_reset_a: assert property (
    @(posedge core_clk) $rose(rstn) |-> chan1_negotiation_pending)
    else $error("Pending not set out of reset");

  active_gate_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      chan1_active |-> $past(!chan1_negotiation_pending
                             && link_state.chan1_enable))
    else $error("Channel active while pending or disabled");

  latency_lock_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      latency_locked |=> $stable(l1_exit_latency))
    else $error("Exit latency changed after lock");

  latency_default_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      !latency_locked |->
        l1_exit_latency == hub_link_regs_pkg::LATENCY_RESET)
    else $error("Exit latency left default before any write");

  cap_fixed_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      (reg_req.valid && !reg_req.write
       && reg_req.addr[11:2] == hub_link_regs_pkg::LINK_CAP_OFS[11:2])
      |=> reg_rsp.ack
          && reg_rsp.rdata[14:0] == hub_link_regs_pkg::LINK_CAP_RESET[14:0]
          && reg_rsp.rdata[31:18] == 14'h0000)
    else $error("Fixed capability bits wrong");

  status_read_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      (reg_req.valid && !reg_req.write
       && reg_req.addr[11:2] == hub_link_regs_pkg::VC1_STATUS_DWORD[11:2])
      |=> reg_rsp.rdata[17] == $past(chan1_negotiation_pending)
          && reg_rsp.rdata[16] == 1'b0)
    else $error("Status read does not show pending");

  ack_timing_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
      reg_req.valid |=> reg_rsp.ack)
    else $error("Request not acknowledged next cycle");

endmodule : hub_link_vc1_status_and_caps

`default_nettype wire

/* verification/link_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Far-end link model
// ****
module link_partner (
  // Clock
  input  wire logic                       core_clk,
  // Link state seen by the hub
  output var hub_link_regs_pkg::link_state_t ls
);
  initial ls = '0;
  // Init stage two exits once; enable held
  task automatic up();
    @(negedge core_clk);
    ls.dl_down = 1'h0;
    ls.chan1_enable = 1'h1;
    ls.fc_init2_exit = 1'h1;
    @(negedge core_clk);
    ls.fc_init2_exit = 1'h0;
  endtask : up
  task automatic drop(input logic dl, input logic en);
    @(negedge core_clk);
    ls.dl_down = dl;
    ls.chan1_enable = en;
  endtask : drop
endmodule : link_partner
`default_nettype wire

/* verification/tb_hub_link_vc1_status_and_caps.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_hub_link_vc1_status_and_caps;
  logic                           core_clk;
  logic                           rstn;
  hub_link_regs_pkg::reg_req_t    req;
  hub_link_regs_pkg::reg_rsp_t    rsp;
  hub_link_regs_pkg::link_state_t ls;
  logic                           pend;
  logic [2:0]                     lat;
  logic                           act;
  logic [31:0]                    rd;
  int                             fails;
  int                             n_compared;
  localparam logic [11:0] CAP = hub_link_regs_pkg::LINK_CAP_OFS;

  hub_link_vc1_status_and_caps dut (.core_clk(core_clk), .rstn(rstn),
    .reg_req(req), .reg_rsp(rsp), .link_state(ls),
    .chan1_negotiation_pending(pend), .l1_exit_latency(lat),
    .chan1_active(act));
  link_partner partner (.core_clk(core_clk), .ls(ls));

  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Answer is sampled mid-cycle, the one cycle it stands
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(negedge core_clk);
    req = '{1'h1, w, a, 4'hf, wd};
    @(negedge core_clk);
    chk("ack", 32'h1, {31'h0, rsp.ack});
    rd = rsp.rdata;
    req.valid = 1'h0;
  endtask : acc

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    acc(1'h0, CAP, 32'h0);
    chk("cap", 32'h0001_2c41, rd);
    chk("lat", 32'h2, {29'h0, lat});
    acc(1'h0, 12'h024, 32'h0);
    chk("status", 32'h2, {16'h0, rd[31:16]});
    chk("pend", 32'h1, {31'h0, pend});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_link();
    partner.drop(1'h0, 1'h1);
    repeat (3) @(negedge core_clk);
    chk("pend", 32'h1, {31'h0, pend});
    partner.up();
    @(negedge core_clk);
    chk("pend", 32'h0, {31'h0, pend});
    chk("act", 32'h1, {31'h0, act});
    acc(1'h0, 12'h024, 32'h0);
    chk("status", 32'h0, {16'h0, rd[31:16]});
    partner.drop(1'h1, 1'h1);
    @(negedge core_clk);
    chk("pend", 32'h1, {31'h0, pend});
    @(negedge core_clk);
    chk("act", 32'h0, {31'h0, act});
    partner.up();
    partner.drop(1'h0, 1'h0);
    repeat (2) @(negedge core_clk);
    chk("pend", 32'h1, {31'h0, pend});
    chk("act", 32'h0, {31'h0, act});
    $display("t_link done");
  endtask : t_link
  task automatic t_lock();
    // Whole field in one access
    acc(1'h1, CAP, 32'hffff_ffff);
    chk("lat", 32'h7, {29'h0, lat});
    acc(1'h0, CAP, 32'h0);
    chk("cap", 32'h0003_ac41, rd);
    chk("pm", 32'h3, {30'h0, rd[11:10]});
    chk("lanes", 32'h4, {26'h0, rd[9:4]});
    chk("speed", 32'h1, {28'h0, rd[3:0]});
    acc(1'h1, CAP, 32'h0);
    acc(1'h0, CAP, 32'h0);
    chk("locked", 32'h0003_ac41, rd);
    acc(1'h0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("t_lock done");
  endtask : t_lock
  // Reset with the link up, so only reset can set pending
  task automatic t_rst();
    partner.up();
    @(negedge core_clk);
    chk("pend", 32'h0, {31'h0, pend});
    rstn = 1'h0;
    repeat (2) @(negedge core_clk);
    rstn = 1'h1;
    chk("pend", 32'h1, {31'h0, pend});
    chk("lat", 32'h2, {29'h0, lat});
    acc(1'h0, CAP, 32'h0);
    chk("cap", 32'h0001_2c41, rd);
    $display("t_rst done");
  endtask : t_rst

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    fails = 0;
    n_compared = 0;
    rstn = 1'h0;
    req = '0;
    repeat (3) @(negedge core_clk);
    rstn = 1'h1;
    t_reset();
    t_link();
    t_lock();
    t_rst();
    print_verdict();
  end
  // Tests need about 40 cycles
  initial begin
    repeat (1000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule : tb_hub_link_vc1_status_and_caps
`default_nettype wire
